// *** src/vfpd_pkg.sv ***
// shared constants and types for the vliw fetch packet dispatcher
package vfpd_pkg;

    // instruction and packet geometry
    localparam int          INSTR_W       = 32;
    localparam int          PACKET_WORDS  = 8;
    localparam int          ADDR_W        = 32;
    localparam int          WORD_W        = 32;
    localparam int          CHAIN_BIT     = 0;

    // program counter after reset
    localparam logic [31:0] RESET_PC      = 32'h0000_0000;

    // load/store access sizes
    localparam logic [1:0]  SZ_BYTE       = 2'h0;
    localparam logic [1:0]  SZ_HALF       = 2'h1;
    localparam logic [1:0]  SZ_WORD       = 2'h2;

    // byte enable patterns
    localparam logic [3:0]  BE_BYTE       = 4'h1;
    localparam logic [3:0]  BE_HALF_LO    = 4'h3;
    localparam logic [3:0]  BE_HALF_HI    = 4'hc;
    localparam logic [3:0]  BE_WORD       = 4'hf;
    localparam logic [3:0]  BE_NONE       = 4'h0;

    // dispatcher states, one-hot
    typedef enum logic [2:0] {
        ST_START = 3'h1,
        ST_WAIT  = 3'h2,
        ST_ISSUE = 3'h4
    } vfpd_state_t;

    // functional unit targets, lane index of each unit
    typedef enum logic [2:0] {
        FU_L1 = 3'h0,
        FU_S1 = 3'h1,
        FU_M1 = 3'h2,
        FU_D1 = 3'h3,
        FU_D2 = 3'h4,
        FU_M2 = 3'h5,
        FU_S2 = 3'h6,
        FU_L2 = 3'h7
    } vfpd_unit_t;

endpackage

// *** src/vfpd_dispatcher.sv ***
// fetch packet dispatcher with load/store lane formatter
// Functional notes
// - program memory is read one whole packet at a time, 256 bits holding eight 32-bit words.
// - a word whose lowest bit is 1 pulls the following word into the same parallel group.
// - a word whose lowest bit is 0 closes the group, so the next word opens a new one.
// - a group holds at most eight words, each on its own functional unit in the same cycle.
// - a packet may hold anywhere from one eight-word group to eight one-word groups.
// - groups leave at exactly one per clock while the current packet still has some.
// - the next packet is not requested until every group of the current one has left.
// - all words of a group drive their units together, up to eight words per clock.
// - loads and stores address bytes, half-words and full words.
// - a 32-bit register value can be stored as a byte, a half-word or a full word.
// - eight units on two sides of four (logic, shift, multiply, data-address) are the targets.
module vfpd_dispatcher #(
    parameter int FETCH_WORDS = vfpd_pkg::PACKET_WORDS,
    parameter int IW          = vfpd_pkg::INSTR_W
) (
    input  wire logic                          i_clock,
    input  wire logic                          i_rstn,
    // program memory side
    output logic                               o_fetch_req,
    output logic [vfpd_pkg::ADDR_W-1:0]        o_fetch_addr,
    input  wire logic                          i_fetch_valid,
    input  wire logic [FETCH_WORDS*IW-1:0]     i_fetch_data,
    // functional unit side
    output logic                               o_group_valid,
    output logic [FETCH_WORDS-1:0]             o_unit_valid,
    output logic [FETCH_WORDS*IW-1:0]          o_unit_instr,
    output logic [$clog2(FETCH_WORDS):0]       o_issue_count,
    // load/store formatter
    input  wire logic                          i_ls_valid,
    input  wire logic [1:0]                    i_ls_size,
    input  wire logic [1:0]                    i_ls_addr,
    input  wire logic                          i_ls_signed,
    input  wire logic [vfpd_pkg::WORD_W-1:0]   i_ls_store_data,
    input  wire logic [vfpd_pkg::WORD_W-1:0]   i_ls_load_raw,
    output logic                               o_ls_valid,
    output logic [3:0]                         o_ls_byte_en,
    output logic [vfpd_pkg::WORD_W-1:0]        o_ls_store_data,
    output logic [vfpd_pkg::WORD_W-1:0]        o_ls_load_data
);
    import vfpd_pkg::*;

    localparam int                 IDX_W    = $clog2(FETCH_WORDS);
    localparam logic [IDX_W-1:0]   LAST     = IDX_W'(FETCH_WORDS - 1);
    localparam logic [ADDR_W-1:0]  PKT_STEP = ADDR_W'(FETCH_WORDS * IW / 8);

    // the index arithmetic needs a power-of-two packet; units are one per lane
    generate
        if (FETCH_WORDS < 2 || FETCH_WORDS > 8 || (1 << IDX_W) != FETCH_WORDS || IW < 8) begin : g_bad_cfg
            $error("unsupported packet geometry");
        end
    endgenerate

    // lowest word at or above first whose chain bit is clear; last word always closes
    function automatic logic [IDX_W-1:0] group_end(input logic [FETCH_WORDS-1:0] chain,
                                                   input logic [IDX_W-1:0]       first);
        logic [IDX_W-1:0] e;
        e = LAST;
        for (int k = FETCH_WORDS - 2; k >= 0; k--) begin
            if (k >= int'(first) && !chain[k]) begin
                e = IDX_W'(k);
            end
        end
        return e;
    endfunction

    vfpd_state_t       state;
    vfpd_state_t       next_state;
    logic [IW-1:0]     pkt [FETCH_WORDS];
    logic [IDX_W-1:0]  start;
    logic [IDX_W:0]    grp_cnt;

    // chain bits and the current group boundary
    wire logic [FETCH_WORDS-1:0] chain;
    wire logic [IDX_W-1:0]       gend;
    wire logic                   is_issue;
    wire logic                   issue_last;
    wire logic                   take_pkt;
    wire logic [IDX_W:0]         next_issue_count;

    generate
        for (genvar c = 0; c < FETCH_WORDS; c++) begin : g_chain
            assign chain[c] = pkt[c][CHAIN_BIT];
        end
    endgenerate

    assign gend             = group_end(chain, start);
    assign is_issue         = (state == ST_ISSUE);
    assign issue_last       = is_issue && (gend == LAST);
    assign take_pkt         = (state == ST_WAIT) && o_fetch_req && i_fetch_valid;
    assign next_issue_count = is_issue ? ({1'b0, gend} - {1'b0, start} + (IDX_W + 1)'(1)) : '0;

    // lane j carries word start+j while it lies inside the group
    wire logic [FETCH_WORDS-1:0]    next_unit_valid;
    wire logic [FETCH_WORDS*IW-1:0] next_unit_instr;

    generate
        for (genvar j = 0; j < FETCH_WORDS; j++) begin : g_lane
            wire logic [IDX_W:0] src;
            assign src = {1'b0, start} + (IDX_W + 1)'(j);
            assign next_unit_valid[j] = is_issue && (src <= {1'b0, gend});
            assign next_unit_instr[j*IW +: IW] =
                next_unit_valid[j] ? pkt[src[IDX_W-1:0]] : '0;
        end
    endgenerate

    // sequencing: request, wait for the packet, then drain it group by group
    always_comb begin
        next_state = state;
        case (state)
            ST_START: next_state = ST_WAIT;
            ST_WAIT:  next_state = take_pkt ? ST_ISSUE : ST_WAIT;
            ST_ISSUE: next_state = issue_last ? ST_WAIT : ST_ISSUE;
            default:  next_state = ST_START;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            state <= ST_START;
        end else begin
            state <= next_state;
        end
    end

    // fetch request goes up only once the packet is empty
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            o_fetch_req  <= 1'b0;
            o_fetch_addr <= RESET_PC;
        end else if (state == ST_START || issue_last) begin
            o_fetch_req  <= 1'b1;
            o_fetch_addr <= (state == ST_START) ? RESET_PC : o_fetch_addr + PKT_STEP;
        end else if (take_pkt) begin
            o_fetch_req  <= 1'b0;
        end
    end

    // whole packet captured in one cycle
    generate
        for (genvar w = 0; w < FETCH_WORDS; w++) begin : g_pkt
            always_ff @(posedge i_clock) begin
                if (!i_rstn) begin
                    pkt[w] <= '0;
                end else if (take_pkt) begin
                    pkt[w] <= i_fetch_data[w*IW +: IW];
                end
            end
        end
    endgenerate

    // scan pointer and per-packet group count
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            start   <= '0;
            grp_cnt <= '0;
        end else if (take_pkt) begin
            start   <= '0;
            grp_cnt <= '0;
        end else if (is_issue) begin
            start   <= gend + IDX_W'(1);
            grp_cnt <= grp_cnt + (IDX_W + 1)'(1);
        end
    end

    // unit outputs registered so every lane changes on the same edge
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            o_group_valid <= 1'b0;
            o_unit_valid  <= '0;
            o_unit_instr  <= '0;
            o_issue_count <= '0;
        end else begin
            o_group_valid <= is_issue;
            o_unit_valid  <= next_unit_valid;
            o_unit_instr  <= next_unit_instr;
            o_issue_count <= next_issue_count;
        end
    end

    // store lane steering and load extraction; half ignores address bit 0, word ignores both address bits
    wire logic [3:0]        next_byte_en;
    wire logic [WORD_W-1:0] next_store;
    wire logic [WORD_W-1:0] shifted;
    wire logic [WORD_W-1:0] next_load;

    assign next_byte_en = (i_ls_size == SZ_BYTE) ? (BE_BYTE << i_ls_addr) :
                          (i_ls_size == SZ_HALF) ? (i_ls_addr[1] ? BE_HALF_HI : BE_HALF_LO) :
                          (i_ls_size == SZ_WORD) ? BE_WORD : BE_NONE;
    assign next_store   = (i_ls_size == SZ_BYTE) ? {4{i_ls_store_data[7:0]}} :
                          (i_ls_size == SZ_HALF) ? {2{i_ls_store_data[15:0]}} :
                          i_ls_store_data;
    assign shifted      = (i_ls_size == SZ_HALF) ? (i_ls_load_raw >> {i_ls_addr[1], 4'h0}) :
                          (i_ls_load_raw >> {i_ls_addr, 3'h0});
    assign next_load    = (i_ls_size == SZ_BYTE) ? {{24{i_ls_signed & shifted[7]}}, shifted[7:0]} :
                          (i_ls_size == SZ_HALF) ? {{16{i_ls_signed & shifted[15]}}, shifted[15:0]} :
                          i_ls_load_raw;

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            o_ls_valid      <= 1'b0;
            o_ls_byte_en    <= BE_NONE;
            o_ls_store_data <= '0;
            o_ls_load_data  <= '0;
        end else begin
            o_ls_valid      <= i_ls_valid;
            o_ls_byte_en    <= i_ls_valid ? next_byte_en : BE_NONE;
            o_ls_store_data <= next_store;
            o_ls_load_data  <= next_load;
        end
    end

    // checks on the dispatcher and the formatter
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    fetch_after_drain_a: assert property ($rose(o_fetch_req) && $past(state) != ST_START
                                          |-> $past(issue_last))
        else $error("fetch requested before packet drained");

    one_per_clock_a: assert property (is_issue |=> o_group_valid && o_unit_valid[0])
        else $error("issue cycle produced no group");

    chain_join_a: assert property (is_issue && start != LAST && chain[start]
                                   |=> o_unit_valid[1])
        else $error("chained word not issued with its predecessor");

    chain_break_a: assert property (is_issue && !chain[start] && start != LAST
                                    |=> o_unit_valid == FETCH_WORDS'(1) && start == $past(start) + IDX_W'(1))
        else $error("cleared chain bit did not close the group");

    last_word_end_a: assert property (is_issue && start == LAST
                                      |=> o_unit_valid == FETCH_WORDS'(1) && o_fetch_req && o_group_valid
                                          ##1 !o_group_valid)
        else $error("last word did not end its group");

    lanes_contig_a: assert property (o_group_valid |-> o_unit_valid[0] &&
                                     ((o_unit_valid + FETCH_WORDS'(1)) & o_unit_valid) == '0)
        else $error("group lanes not contiguous from lane zero");

    group_count_a: assert property (issue_last |-> grp_cnt < (IDX_W + 1)'(FETCH_WORDS))
        else $error("too many groups in one packet");

    issue_width_a: assert property (o_group_valid |-> o_issue_count == ($countones(o_unit_valid)))
        else $error("issue count disagrees with active lanes");

    first_word_a: assert property (take_pkt |=> is_issue ##1 o_unit_instr[IW-1:0] == $past(i_fetch_data[IW-1:0], 2))
        else $error("first group did not start at lowest word");

    store_byte_a: assert property (i_ls_valid && i_ls_size == SZ_BYTE
                                   |=> $countones(o_ls_byte_en) == 1 && o_ls_store_data[7:0] == $past(i_ls_store_data[7:0]))
        else $error("byte store steering wrong");

    word_access_a: assert property (i_ls_valid && i_ls_size == SZ_WORD |=> o_ls_byte_en == BE_WORD)
        else $error("word access lacks full byte enables");

    full_group_c:    cover property (o_group_valid && o_issue_count == (IDX_W + 1)'(FETCH_WORDS));
    all_single_c:    cover property (issue_last && grp_cnt == (IDX_W + 1)'(FETCH_WORDS - 1));
    byte_store_c:    cover property (i_ls_valid && i_ls_size == SZ_BYTE && i_ls_addr == 2'h3);
    signed_half_c:   cover property (i_ls_valid && i_ls_size == SZ_HALF && i_ls_signed);

endmodule

// *** verif/vfpd_prog_mem.sv ***
// program memory model answering fetch requests with whole packets
module vfpd_prog_mem (
    input  wire logic         i_clock,
    input  wire logic         i_rstn,
    input  wire logic         i_fetch_req,
    input  wire logic [1:0]   i_mode,
    output logic              o_fetch_valid,
    output logic [255:0]      o_fetch_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int gap;

    // chain bits by mode: 0 random, 1 all chained, 2 none, 3 chained through the last word
    function automatic logic [255:0] make_packet(input logic [1:0] mode);
        logic [255:0] p;
        for (int w = 0; w < 8; w++) begin
            p[32*w +: 32] = $urandom;
            if (mode[0]) p[32*w] = 1'b1;
            if (mode == 2'h2) p[32*w] = 1'b0;
        end
        if (mode != 2'h3) p[224] = 1'b0; // no group runs past the packet
        return p;
    endfunction

    // whole packet per take, random stall before answering; idle data churns
    always @(posedge i_clock) begin
        if (!i_rstn) begin
            o_fetch_valid <= 1'b0;
            o_fetch_data <= 256'h0;
            gap <= 0;
        end else if (o_fetch_valid && i_fetch_req) begin
            o_fetch_valid <= 1'b0;
            o_fetch_data <= ~o_fetch_data;
            gap <= $urandom % 3;
        end else if (i_fetch_req && !o_fetch_valid && gap == 0) begin
            o_fetch_valid <= 1'b1;
            o_fetch_data <= make_packet(i_mode);
        end else if (!o_fetch_valid) begin
            o_fetch_data <= ~o_fetch_data;
            if (gap > 0) gap <= gap - 1;
        end
    end
endmodule

// *** verif/test_vliw_fetch_packet_dispatcher.sv ***
// self-checking bench for the fetch packet dispatcher
module test_vliw_fetch_packet_dispatcher;
    timeunit 1ns;
    timeprecision 1ps;
    import vfpd_pkg::*;
    logic         i_clock = 1'b0, i_rstn = 1'b0, i_ls_valid = 1'b0, i_ls_signed = 1'b0;
    logic [1:0]   i_ls_size = 2'h0, i_ls_addr = 2'h0, mode = 2'h0;
    logic [31:0]  i_ls_store_data = 32'h0, i_ls_load_raw = 32'h0, fetch_addr, ls_st, ls_ld, exp_addr, e_st, e_ld, sh;
    logic         fetch_req, fetch_valid, group_valid, ls_v, e_v, e_rsv;
    logic [255:0] fetch_data, unit_instr;
    logic [7:0]   unit_valid;
    logic [3:0]   issue_count, ls_be, e_be;
    logic [7:0]   q_mask[$];
    logic [255:0] q_instr[$];
    int           n_errors = 0, cmp_count = 0, n_takes = 0, due = 0, cycles = 0, start;
    bit           ls_armed = 0;

    vfpd_dispatcher dut (.i_clock(i_clock), .i_rstn(i_rstn), .o_fetch_req(fetch_req), .o_fetch_addr(fetch_addr),
        .i_fetch_valid(fetch_valid), .i_fetch_data(fetch_data), .o_group_valid(group_valid),
        .o_unit_valid(unit_valid), .o_unit_instr(unit_instr), .o_issue_count(issue_count),
        .i_ls_valid(i_ls_valid), .i_ls_size(i_ls_size), .i_ls_addr(i_ls_addr), .i_ls_signed(i_ls_signed),
        .i_ls_store_data(i_ls_store_data), .i_ls_load_raw(i_ls_load_raw), .o_ls_valid(ls_v),
        .o_ls_byte_en(ls_be), .o_ls_store_data(ls_st), .o_ls_load_data(ls_ld));
    vfpd_prog_mem mem (.i_clock(i_clock), .i_rstn(i_rstn), .i_fetch_req(fetch_req), .i_mode(mode),
        .o_fetch_valid(fetch_valid), .o_fetch_data(fetch_data));

    always #5 i_clock = ~i_clock;

    task automatic check_val(input logic [255:0] act, input logic [255:0] exp, input string what);
        cmp_count++;
        if (act !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, act, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // packs each group into lanes from lane 0, scanning low words first
    task automatic split_packet(input logic [255:0] p);
        logic [7:0]   m;
        logic [255:0] ins;
        int           k;
        m = 8'h0;
        ins = 256'h0;
        k = 0;
        for (int w = 0; w < 8; w++) begin
            ins[32*k +: 32] = p[32*w +: 32];
            m[k] = 1'b1;
            k++;
            if (p[32*w] == 1'b0 || w == 7) begin
                q_mask.push_back(m);
                q_instr.push_back(ins);
                m = 8'h0;
                ins = 256'h0;
                k = 0;
            end
        end
    endtask

    // random load/store traffic, launched at the rising edge
    always @(posedge i_clock) begin
        i_ls_valid <= $urandom;
        i_ls_size <= $urandom;
        i_ls_addr <= $urandom;
        i_ls_signed <= $urandom;
        i_ls_store_data <= $urandom;
        i_ls_load_raw <= $urandom;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            $display("wrong value at %0t: run timed out", $time);
            stop_test();
        end
    end

    // reference model, sampled mid-cycle where outputs have settled
    always @(negedge i_clock) begin
        if (!i_rstn) begin
            if (cycles > 1) check_val({fetch_req, group_valid, ls_v}, 0, "reset outputs");
            exp_addr = 32'h0;
            ls_armed = 0;
            due = 0;
        end else begin
            if (due == 1) check_val(group_valid, 1'b1, "group slot");
            if (due > 0) due--;
            if (group_valid === 1'b1 && q_mask.size() == 0) check_val(1, 0, "unexpected group");
            else if (group_valid === 1'b1) begin
                check_val(unit_valid, q_mask[0], "lanes");
                check_val(unit_instr, q_instr[0], "instructions");
                check_val(issue_count, $countones(q_mask[0]), "issue count");
                void'(q_mask.pop_front());
                void'(q_instr.pop_front());
                if (q_mask.size() > 0) due = 1;
            end
            if (fetch_req === 1'b1) check_val(q_mask.size(), 0, "early fetch");
            if (fetch_req === 1'b1 && fetch_valid === 1'b1) begin
                check_val(fetch_addr, exp_addr, "fetch address");
                exp_addr += 32;
                split_packet(fetch_data);
                due = 2;
                n_takes++;
            end
            if (ls_armed) begin
                check_val(ls_v, e_v, "ls valid");
                check_val(ls_be, e_be, "byte enables");
                if (e_v && !e_rsv) check_val(ls_st, e_st, "store lanes");
                if (!e_rsv) check_val(ls_ld, e_ld, "load extract");
            end
            e_v = i_ls_valid;
            e_rsv = (i_ls_size == 2'h3);
            e_st = (i_ls_size == SZ_BYTE) ? {4{i_ls_store_data[7:0]}} :
                   (i_ls_size == SZ_HALF) ? {2{i_ls_store_data[15:0]}} : i_ls_store_data;
            sh = i_ls_load_raw >> ((i_ls_size == SZ_BYTE) ? 8 * i_ls_addr : 16 * i_ls_addr[1]);
            e_ld = (i_ls_size == SZ_BYTE) ? {{24{i_ls_signed & sh[7]}}, sh[7:0]} :
                   (i_ls_size == SZ_HALF) ? {{16{i_ls_signed & sh[15]}}, sh[15:0]} : i_ls_load_raw;
            e_be = (!i_ls_valid || e_rsv) ? BE_NONE : (i_ls_size == SZ_BYTE) ? (4'h1 << i_ls_addr) :
                   (i_ls_size == SZ_HALF) ? (i_ls_addr[1] ? BE_HALF_HI : BE_HALF_LO) : BE_WORD;
            ls_armed = 1;
        end
    end

    // modes: random chains, one eight-word group, eight single groups, chain bit on the last word
    initial begin
        void'($urandom(11291));
        repeat (20) @(posedge i_clock);
        i_rstn <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            mode <= m[1:0];
            start = n_takes;
            while (n_takes < start + 6) @(posedge i_clock);
            $display("test packet mode %0d done", m);
        end
        // let the last packet drain so its groups are compared too
        while (q_mask.size() > 0) @(posedge i_clock);
        stop_test();
    end
endmodule
